// >>> spm_data_memory.sv
// scratch-pad data memory, register banks and core special function registers
//
// Function
// (RL1) special registers reached only by direct address
// (RL2) ram reachable directly and through pointer registers
// (RL3) four sets of eight 8-bit working registers
// (RL4) sets zero to three fill bytes 00h-1fh
// (RL5) one set active, chosen by bank-select field
// (RL6) registers zero and one serve as pointers
// (RL7) bytes 20h-2fh bit addressable, bits 00-7f
// (RL8) stack pointer at 81h, resets to 07h
// (RL9) 82h/83h form data pointer, low resets zero
// (RL10) port 0 open-drain, pull-ups when option set
// (RL11) port 0 multiplexes address and data externally
// (RL12) serial location: read receive, write transmit
// (RL13) bytes 80h-ffh indirect only; direct hits registers
// (RL14) push pre-increments, pop post-decrements stack pointer
`timescale 1ns/1ps
`default_nettype none

module spm_data_memory #(
  parameter int EXT_DATA_CYC = spm_pkg::EXT_DATA_CYC
) (
  // clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // core request and answer
  input  wire spm_pkg::spm_req_t    core_req,
  input  wire logic [1:0]           bank_select,
  output logic [7:0]                rd_data,
  output logic                      rd_valid,
  output logic [7:0]                stack_top_pointer,
  output logic [15:0]               data_pointer_16,
  // serial buffer side
  input  wire logic                 rx_load,
  input  wire logic [7:0]           rx_byte,
  output logic [7:0]                tx_byte,
  output logic                      tx_load,
  // external memory access
  input  wire spm_pkg::spm_ext_req_t ext_req,
  output logic                      ext_busy,
  output logic                      ext_addr_strobe,
  output logic [7:0]                ext_rdata,
  output logic                      ext_done,
  // port 0 pins
  input  wire logic [7:0]           p0_in,
  output logic [7:0]                p0_out,
  output logic [7:0]                p0_oe_n,
  output logic [7:0]                p0_pullup
);

  localparam logic [7:0] DATA_LAST = 8'(EXT_DATA_CYC - 1);

  // byte that holds a given bit address
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    if (b[7]) begin
      return {b[7:3], 3'b000};
    end
    return spm_pkg::BIT_BASE + {4'h0, b[6:3]}; // RL7
  endfunction

  // byte with one bit replaced
  function automatic logic [7:0] bit_put(input logic [7:0] v, input logic [2:0] n,
                                         input logic bv);
    logic [7:0] r;
    r = v;
    r[n] = bv;
    return r;
  endfunction

  logic [7:0] ram [spm_pkg::RAM_DEPTH];

  logic [7:0] port_zero_latch, port_zero_pullup_option_reg;
  logic [7:0] data_pointer_low_byte, data_pointer_high_byte, rx_buf;
  logic [7:0] p0_s1, p0_s2, p0_s3, p0_filt;

  logic [7:0] next_port_zero_latch, next_pullup_reg, next_stack_top_pointer;
  logic [7:0] next_data_pointer_16_lo, next_data_pointer_16_hi, next_rx_buf, next_tx_byte;
  logic [7:0] next_rd_data, next_p0_filt;
  logic       next_tx_load, next_rd_valid;

  logic [7:0] ri_val, reg_addr, byte_addr, sfr_addr;
  logic [7:0] sfr_rdata, cur_byte, wr_byte;
  logic       is_sfr, is_rd, is_wr, use_latch, ram_we;

  // active bank picks the window of eight bytes at bank*8
  assign reg_addr = {3'b000, bank_select, core_req.addr[2:0]}; // RL3 RL4 RL5
  assign ri_val   = ram[{3'b000, bank_select, 2'b00, core_req.addr[0]}]; // RL6

  // request decode: which byte, ram or register space, read or write
  always_comb begin
    byte_addr = core_req.addr;
    is_sfr    = 1'b0;
    is_rd     = 1'b0;
    is_wr     = 1'b0;
    unique case (core_req.op)
      spm_pkg::OP_DIR_RD, spm_pkg::OP_DIR_WR: begin
        is_sfr = core_req.addr >= spm_pkg::SFR_BASE; // RL13 RL1
      end
      spm_pkg::OP_IND_RD, spm_pkg::OP_IND_WR: byte_addr = ri_val; // RL2 RL1
      spm_pkg::OP_REG_RD, spm_pkg::OP_REG_WR: byte_addr = reg_addr;
      spm_pkg::OP_BIT_RD, spm_pkg::OP_BIT_WR: begin
        byte_addr = bit_byte(core_req.addr); // RL7
        is_sfr    = core_req.addr[7];
      end
      spm_pkg::OP_PUSH: byte_addr = stack_top_pointer + 8'h01; // RL14
      spm_pkg::OP_POP:  byte_addr = stack_top_pointer; // RL14
      default:          byte_addr = core_req.addr;
    endcase
    unique case (core_req.op)
      spm_pkg::OP_DIR_RD, spm_pkg::OP_IND_RD, spm_pkg::OP_REG_RD,
      spm_pkg::OP_BIT_RD, spm_pkg::OP_POP: is_rd = 1'b1;
      spm_pkg::OP_DIR_WR, spm_pkg::OP_IND_WR, spm_pkg::OP_REG_WR,
      spm_pkg::OP_BIT_WR, spm_pkg::OP_PUSH: is_wr = 1'b1;
      default: is_rd = 1'b0;
    endcase
  end

  // register read mux; pins are read unless the access modifies the latch
  assign sfr_addr  = byte_addr;
  assign use_latch = core_req.rmw | (core_req.op == spm_pkg::OP_BIT_WR);
  always_comb begin
    unique case (sfr_addr)
      spm_pkg::SFR_PORT0:   sfr_rdata = use_latch ? port_zero_latch : p0_filt;
      spm_pkg::SFR_STACK:   sfr_rdata = stack_top_pointer; // RL8
      spm_pkg::SFR_DATA_POINTER_16_LO: sfr_rdata = data_pointer_low_byte; // RL9
      spm_pkg::SFR_DATA_POINTER_16_HI: sfr_rdata = data_pointer_high_byte; // RL9
      spm_pkg::SFR_PULLUP:  sfr_rdata = port_zero_pullup_option_reg;
      spm_pkg::SFR_SERIAL:  sfr_rdata = rx_buf; // RL12
      default:              sfr_rdata = spm_pkg::UNMAPPED_RD;
    endcase
  end

  assign cur_byte = is_sfr ? sfr_rdata : ram[byte_addr];
  // bit writes merge into the byte just read
  assign wr_byte  = (core_req.op == spm_pkg::OP_BIT_WR) ?
                    bit_put(cur_byte, core_req.addr[2:0], core_req.wdata[0]) :
                    core_req.wdata;
  assign ram_we   = is_wr & ~is_sfr;

  // next values of registers and the read answer
  always_comb begin
    next_port_zero_latch   = port_zero_latch;
    next_pullup_reg        = port_zero_pullup_option_reg;
    next_stack_top_pointer = stack_top_pointer;
    next_data_pointer_16_lo           = data_pointer_low_byte;
    next_data_pointer_16_hi           = data_pointer_high_byte;
    next_tx_byte           = tx_byte;
    next_tx_load           = 1'b0;
    next_rd_data           = rd_data;
    next_rd_valid          = 1'b0;
    next_rx_buf            = rx_load ? rx_byte : rx_buf;
    if (is_rd) begin
      next_rd_valid = 1'b1;
      next_rd_data  = (core_req.op == spm_pkg::OP_BIT_RD) ?
                      {7'h00, cur_byte[core_req.addr[2:0]]} : cur_byte;
    end
    if (is_wr && is_sfr) begin
      unique case (sfr_addr)
        spm_pkg::SFR_PORT0:   next_port_zero_latch = wr_byte;
        spm_pkg::SFR_STACK:   next_stack_top_pointer = wr_byte;
        spm_pkg::SFR_DATA_POINTER_16_LO: next_data_pointer_16_lo = wr_byte;
        spm_pkg::SFR_DATA_POINTER_16_HI: next_data_pointer_16_hi = wr_byte;
        spm_pkg::SFR_PULLUP:  next_pullup_reg = wr_byte;
        spm_pkg::SFR_SERIAL: begin
          next_tx_byte = wr_byte; // RL12
          next_tx_load = 1'b1;
        end
        default: next_tx_load = 1'b0;
      endcase
    end
    // stack moves around its own ram access
    if (core_req.op == spm_pkg::OP_PUSH) begin
      next_stack_top_pointer = stack_top_pointer + 8'h01; // RL14
    end
    if (core_req.op == spm_pkg::OP_POP) begin
      next_stack_top_pointer = stack_top_pointer - 8'h01; // RL14
    end
  end

  // register state; the ram itself has no reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_zero_latch             <= spm_pkg::RST_PORT0; // RL10
      port_zero_pullup_option_reg <= spm_pkg::RST_PULLUP;
      stack_top_pointer           <= spm_pkg::RST_STACK; // RL8
      data_pointer_low_byte       <= spm_pkg::RST_DATA_POINTER_16_LO; // RL9
      data_pointer_high_byte      <= spm_pkg::RST_DATA_POINTER_16_HI;
      rx_buf                      <= spm_pkg::RST_SERIAL;
      tx_byte                     <= spm_pkg::RST_SERIAL;
      tx_load                     <= 1'b0;
      rd_data                     <= spm_pkg::RST_RDATA;
      rd_valid                    <= 1'b0;
    end else if (ce) begin
      port_zero_latch             <= next_port_zero_latch;
      port_zero_pullup_option_reg <= next_pullup_reg;
      stack_top_pointer           <= next_stack_top_pointer;
      data_pointer_low_byte       <= next_data_pointer_16_lo;
      data_pointer_high_byte      <= next_data_pointer_16_hi;
      rx_buf                      <= next_rx_buf;
      tx_byte                     <= next_tx_byte;
      tx_load                     <= next_tx_load;
      rd_data                     <= next_rd_data;
      rd_valid                    <= next_rd_valid;
    end
  end

  // scratch-pad storage
  always_ff @(posedge ref_clk) begin
    if (ce && !rst && ram_we) begin
      ram[byte_addr] <= wr_byte; // RL2
    end
  end

  // data_pointer_16 bytes shown together as one 16-bit pointer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_pointer_16 <= {spm_pkg::RST_DATA_POINTER_16_HI, spm_pkg::RST_DATA_POINTER_16_LO};
    end else if (ce) begin
      data_pointer_16 <= {next_data_pointer_16_hi, next_data_pointer_16_lo}; // RL9
    end
  end

  // pin filter: a change is taken once stages two and three agree
  assign next_p0_filt = ((p0_s2 ^ p0_s3) & p0_filt) | (~(p0_s2 ^ p0_s3) & p0_s3);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      p0_s1   <= 8'hff;
      p0_s2   <= 8'hff;
      p0_s3   <= 8'hff;
      p0_filt <= 8'hff;
    end else if (ce) begin
      p0_s1   <= p0_in;
      p0_s2   <= p0_s1;
      p0_s3   <= p0_s2;
      p0_filt <= next_p0_filt;
    end
  end

  // external access sequencer
  spm_pkg::spm_ext_state_t ext_state, next_ext_state;
  logic [7:0] ext_cnt, next_ext_cnt, ext_alo, next_ext_alo, ext_wd, next_ext_wd;
  logic [7:0] next_ext_rdata, next_p0_out, next_p0_oe_n;
  logic       ext_wr, next_ext_wr, next_ext_done, next_ext_strobe;

  always_comb begin
    next_ext_state  = ext_state;
    next_ext_cnt    = ext_cnt;
    next_ext_wr     = ext_wr;
    next_ext_alo    = ext_alo;
    next_ext_wd     = ext_wd;
    next_ext_rdata  = ext_rdata;
    next_ext_done   = 1'b0;
    next_ext_strobe = 1'b0;
    unique case (ext_state)
      spm_pkg::EXT_IDLE: begin
        if (ext_req.go) begin
          next_ext_state  = spm_pkg::EXT_ADDR;
          next_ext_wr     = ext_req.write;
          next_ext_alo    = ext_req.addr_lo;
          next_ext_wd     = ext_req.wdata;
          next_ext_strobe = 1'b1;
        end
      end
      spm_pkg::EXT_ADDR: begin
        next_ext_state = spm_pkg::EXT_DATA;
        next_ext_cnt   = DATA_LAST;
      end
      spm_pkg::EXT_DATA: begin
        if (ext_cnt == 8'h00) begin
          next_ext_state = spm_pkg::EXT_IDLE;
          next_ext_done  = 1'b1;
          // filter value due now; four data cycles let the byte settle through it
          if (!ext_wr) begin
            next_ext_rdata = next_p0_filt;
          end
        end else begin
          next_ext_cnt = ext_cnt - 8'h01;
        end
      end
      default: next_ext_state = spm_pkg::EXT_IDLE;
    endcase
    // pins: address then data during external access, else the latch
    unique case (next_ext_state)
      spm_pkg::EXT_ADDR: begin
        next_p0_out  = next_ext_alo; // RL11
        next_p0_oe_n = 8'h00;
      end
      spm_pkg::EXT_DATA: begin
        next_p0_out  = next_ext_wd; // RL11
        next_p0_oe_n = next_ext_wr ? 8'h00 : 8'hff;
      end
      default: begin
        // latch ones release the pin: open drain only pulls low
        next_p0_out  = next_port_zero_latch; // RL10
        next_p0_oe_n = next_port_zero_latch;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_state       <= spm_pkg::EXT_IDLE;
      ext_cnt         <= 8'h00;
      ext_wr          <= 1'b0;
      ext_alo         <= 8'h00;
      ext_wd          <= 8'h00;
      ext_rdata       <= 8'h00;
      ext_done        <= 1'b0;
      ext_addr_strobe <= 1'b0;
      ext_busy        <= 1'b0;
      p0_out          <= spm_pkg::RST_PORT0;
      p0_oe_n         <= spm_pkg::RST_PORT0;
      p0_pullup       <= 8'h00;
    end else if (ce) begin
      ext_state       <= next_ext_state;
      ext_cnt         <= next_ext_cnt;
      ext_wr          <= next_ext_wr;
      ext_alo         <= next_ext_alo;
      ext_wd          <= next_ext_wd;
      ext_rdata       <= next_ext_rdata;
      ext_done        <= next_ext_done;
      ext_addr_strobe <= next_ext_strobe;
      ext_busy        <= next_ext_state != spm_pkg::EXT_IDLE;
      p0_out          <= next_p0_out;
      p0_oe_n         <= next_p0_oe_n;
      p0_pullup       <= {8{next_pullup_reg[spm_pkg::PULLUP_BIT]}}; // RL10
    end
  end

endmodule

`default_nettype wire

// >>> spm_pkg.sv
// constants and carrier types for the scratch-pad data memory and its registers
package spm_pkg;

  // direct addresses of the registers kept in this block
  localparam logic [7:0] SFR_PORT0   = 8'h80;
  localparam logic [7:0] SFR_STACK   = 8'h81;
  localparam logic [7:0] SFR_DATA_POINTER_16_LO = 8'h82;
  localparam logic [7:0] SFR_DATA_POINTER_16_HI = 8'h83;
  localparam logic [7:0] SFR_PULLUP  = 8'h8f;
  localparam logic [7:0] SFR_SERIAL  = 8'h99;

  // values after reset
  localparam logic [7:0] RST_PORT0   = 8'hff;
  localparam logic [7:0] RST_STACK   = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_16_LO = 8'h00;
  localparam logic [7:0] RST_DATA_POINTER_16_HI = 8'h00;
  localparam logic [7:0] RST_PULLUP  = 8'h00;
  localparam logic [7:0] RST_SERIAL  = 8'h00;
  localparam logic [7:0] RST_RDATA   = 8'h00;

  // address map of the scratch-pad
  localparam logic [7:0] BIT_BASE    = 8'h20;
  localparam logic [7:0] SFR_BASE    = 8'h80;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam int         PULLUP_BIT  = 0;
  localparam int         RAM_DEPTH   = 256;

  // cycles the port 0 bus is held in the data phase of an external access
  localparam int         EXT_DATA_CYC = 4;

  // operations the execution core may issue, one per cycle
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_DIR_RD = 4'h1,
    OP_DIR_WR = 4'h2,
    OP_IND_RD = 4'h3,
    OP_IND_WR = 4'h4,
    OP_REG_RD = 4'h5,
    OP_REG_WR = 4'h6,
    OP_BIT_RD = 4'h7,
    OP_BIT_WR = 4'h8,
    OP_PUSH   = 4'h9,
    OP_POP    = 4'ha
  } spm_op_t;

  typedef struct packed {
    spm_op_t    op;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spm_req_t;

  typedef struct packed {
    logic       go;
    logic       write;
    logic [7:0] addr_lo;
    logic [7:0] wdata;
  } spm_ext_req_t;

  typedef enum logic [2:0] {
    EXT_IDLE = 3'b001,
    EXT_ADDR = 3'b010,
    EXT_DATA = 3'b100
  } spm_ext_state_t;

endpackage

// >>> spm_data_memory_chk.sv
// port assertions for the scratch-pad data memory
`timescale 1ns/1ps
`default_nettype none
module spm_data_memory_chk #(
  parameter int EXT_DATA_CYC = 4
) (
  // clock, reset, enable
  input wire logic                  ref_clk, rst, ce,
  // core side
  input wire spm_pkg::spm_req_t     core_req,
  input wire logic [1:0]            bank_select,
  input wire logic [7:0]            rd_data, stack_top_pointer,
  input wire logic                  rd_valid,
  input wire logic [15:0]           data_pointer_16,
  // serial side
  input wire logic                  rx_load, tx_load,
  input wire logic [7:0]            rx_byte, tx_byte,
  // external access and pins
  input wire spm_pkg::spm_ext_req_t ext_req,
  input wire logic                  ext_busy, ext_addr_strobe, ext_done,
  input wire logic [7:0]            ext_rdata, p0_in, p0_out, p0_oe_n, p0_pullup
);
  localparam int DONE_LAG = EXT_DATA_CYC + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic taken, is_rd, dwr;
  // read ops are 1,3,5,7 and a
  assign taken = ce && core_req.op != spm_pkg::OP_NONE;
  assign is_rd = core_req.op inside {4'h1, 4'h3, 4'h5, 4'h7, 4'ha};
  assign dwr   = taken && core_req.op == spm_pkg::OP_DIR_WR;
  a_read_answer: assert property (taken && is_rd |=> rd_valid)
    else $error("read not answered in the next cycle");
  // valid is frozen while the enable is low, so only judge cycles after an enabled edge
  a_no_stray_valid: assert property (rd_valid && $past(ce) |-> $past(taken && is_rd))
    else $error("read valid without a read");
  a_push_pre_inc: assert property (taken && core_req.op == spm_pkg::OP_PUSH
    |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01) else $error("push step wrong");
  a_pop_post_dec: assert property (taken && core_req.op == spm_pkg::OP_POP
    |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01) else $error("pop step wrong");
  a_stack_dir_read: assert property (taken && core_req.op == spm_pkg::OP_DIR_RD
    && core_req.addr == spm_pkg::SFR_STACK |=> rd_data == $past(stack_top_pointer))
    else $error("stack pointer read wrong");
  a_data_pointer_16_low_write: assert property (dwr && core_req.addr == spm_pkg::SFR_DATA_POINTER_16_LO
    |=> data_pointer_16[7:0] == $past(core_req.wdata)) else $error("pointer low wrong");
  a_serial_tx_load: assert property (dwr && core_req.addr == spm_pkg::SFR_SERIAL
    |=> tx_load && tx_byte == $past(core_req.wdata)) else $error("transmit load wrong");
  a_pullup_option: assert property (dwr && core_req.addr == spm_pkg::SFR_PULLUP
    |=> p0_pullup == {8{$past(core_req.wdata[0])}}) else $error("pull-up option wrong");
  a_ind_no_sfr: assert property (taken && core_req.op == spm_pkg::OP_IND_WR
    |=> $stable(stack_top_pointer) && $stable(data_pointer_16) && !tx_load)
    else $error("indirect write reached a register");
  a_ext_addr_phase: assert property (ce && !ext_busy && ext_req.go
    |=> ext_addr_strobe && p0_oe_n == 8'h00 && p0_out == $past(ext_req.addr_lo))
    else $error("address phase wrong");
  a_ext_done_lag: assert property (ext_addr_strobe |-> ##DONE_LAG ext_done)
    else $error("external access done late");
  c_push: cover property (taken && core_req.op == spm_pkg::OP_PUSH);
  c_ext_done: cover property (ext_done);
  c_tx_load: cover property (tx_load);
endmodule
bind spm_data_memory spm_data_memory_chk #(.EXT_DATA_CYC(EXT_DATA_CYC)) u_chk (
  .ref_clk, .rst, .ce, .core_req, .bank_select, .rd_data, .stack_top_pointer, .rd_valid,
  .data_pointer_16, .rx_load, .tx_load, .rx_byte, .tx_byte, .ext_req, .ext_busy,
  .ext_addr_strobe, .ext_done, .ext_rdata, .p0_in, .p0_out, .p0_oe_n, .p0_pullup);
`default_nettype wire

// >>> spm_port0_model.sv
// port 0 pin resolution and a small external memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module spm_port0_model (
  // clock
  input wire logic        ref_clk,
  // pins from the block
  input wire logic [7:0]  p0_out, p0_oe_n, p0_pullup,
  input wire logic        ext_busy, ext_addr_strobe,
  // resolved pins and captured write byte
  output logic [7:0]      p0_in,
  output logic [7:0]      wr_seen
);
  logic [7:0] addr_q = 8'h00;
  logic [7:0] last = 8'h00;
  // address byte first, then data byte in the data phase
  always @(posedge ref_clk) begin
    if (ext_addr_strobe) addr_q <= p0_out;
    if (ext_busy && !ext_addr_strobe && p0_oe_n == 8'h00) wr_seen <= p0_out;
    last <= p0_in;
  end
  // released bits: memory answer, else pull-up, else a toggling float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!p0_oe_n[i]) p0_in[i] = p0_out[i];
      else if (ext_busy && !ext_addr_strobe) p0_in[i] = addr_q[i] ^ (i % 2 == 0);
      else if (p0_pullup[i]) p0_in[i] = 1'b1;
      else p0_in[i] = ~last[i];
    end
  end
endmodule
`default_nettype wire

// >>> spm_data_memory_bench.sv
// self-checking bench for the scratch-pad data memory
`timescale 1ns/1ps
`default_nettype none
module spm_data_memory_bench;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, rx_load = 1'b0;
  logic [1:0] bank_select = 2'h0;
  logic [7:0] rx_byte = 8'h00, rd_data, stack_top_pointer, tx_byte, ext_rdata;
  logic [7:0] p0_in, p0_out, p0_oe_n, p0_pullup, wr_seen;
  logic [15:0] data_pointer_16;
  logic rd_valid, tx_load, ext_busy, ext_addr_strobe, ext_done;
  spm_pkg::spm_req_t core_req = '0;
  spm_pkg::spm_ext_req_t ext_req = '0;
  int err_count = 0, n_tests = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  spm_data_memory #(.EXT_DATA_CYC(4)) dut (.ref_clk, .rst, .ce, .core_req, .bank_select,
    .rd_data, .rd_valid, .stack_top_pointer, .data_pointer_16, .rx_load, .rx_byte, .tx_byte,
    .tx_load, .ext_req, .ext_busy, .ext_addr_strobe, .ext_rdata, .ext_done, .p0_in,
    .p0_out, .p0_oe_n, .p0_pullup);
  spm_port0_model far (.ref_clk, .p0_out, .p0_oe_n, .p0_pullup, .ext_busy,
    .ext_addr_strobe, .p0_in, .wr_seen);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end
  // ops: 1 dir rd, 2 dir wr, 3 ind rd, 4 ind wr, 5/6 reg, 7/8 bit, 9 push, a pop
  task automatic wr(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    core_req <= '{spm_pkg::spm_op_t'(op), 1'b0, a, d};
  endtask
  task automatic idle;
    @(posedge ref_clk);
    core_req <= '0;
  endtask
  // answer is compared in the single cycle it stands
  task automatic rd(input logic [3:0] op, input logic [7:0] a, input logic m,
                    input logic [7:0] exp);
    @(posedge ref_clk);
    core_req <= '{spm_pkg::spm_op_t'(op), m, a, 8'h00};
    idle();
    #1;
    check({7'h00, rd_valid, rd_data}, {8'h01, exp});
  endtask
  // one external access, waiting a bounded time for done
  task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    ext_req <= '{1'b1, w, a, d};
    @(posedge ref_clk);
    ext_req <= '0;
    #1;
    check({14'h0000, ext_busy, ext_addr_strobe}, 16'h0003);
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      if (ext_done === 1'b1) break;
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check({stack_top_pointer, p0_pullup}, 16'h0700);
    check(data_pointer_16, 16'h0000);
    check({p0_out, p0_oe_n}, 16'hffff);
    rd(4'h1, 8'h80, 1'b1, 8'hff);
    rd(4'h1, 8'h84, 1'b0, 8'h00);
    // one register seven per set, then all read back directly
    for (int b = 0; b < 4; b++) begin
      @(posedge ref_clk);
      bank_select <= 2'(b);
      wr(4'h6, 8'h07, 8'h10 | 8'(b));
      rd(4'h5, 8'h07, 1'b0, 8'h10 | 8'(b));
    end
    for (int b = 0; b < 4; b++) rd(4'h1, 8'(b * 8 + 7), 1'b0, 8'h10 | 8'(b));
    @(posedge ref_clk);
    bank_select <= 2'h2;
    wr(4'h6, 8'h00, 8'h90);
    wr(4'h6, 8'h01, 8'h81);
    wr(4'h4, 8'h00, 8'ha5);
    wr(4'h4, 8'h01, 8'h3c);
    rd(4'h1, 8'h10, 1'b0, 8'h90);
    rd(4'h1, 8'h90, 1'b0, 8'h00);
    rd(4'h3, 8'h00, 1'b0, 8'ha5);
    rd(4'h1, 8'h81, 1'b0, 8'h07);
    rd(4'h3, 8'h01, 1'b0, 8'h3c);
    wr(4'h2, 8'h23, 8'h00);
    wr(4'h8, 8'h1b, 8'h01);
    wr(4'h2, 8'h2f, 8'h80);
    rd(4'h1, 8'h23, 1'b0, 8'h08);
    rd(4'h7, 8'h7f, 1'b0, 8'h01);
    rd(4'h7, 8'h7e, 1'b0, 8'h00);
    // a write while the enable is low must leave no trace
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(4'h2, 8'h81, 8'haa);
    idle();
    ce <= 1'b1;
    rd(4'h1, 8'h81, 1'b0, 8'h07);
    wr(4'h2, 8'h81, 8'h40);
    wr(4'h9, 8'h00, 8'h5a);
    wr(4'h9, 8'h00, 8'h6b);
    rd(4'h1, 8'h81, 1'b0, 8'h42);
    rd(4'h1, 8'h42, 1'b0, 8'h6b);
    rd(4'ha, 8'h00, 1'b0, 8'h6b);
    rd(4'ha, 8'h00, 1'b0, 8'h5a);
    check({8'h00, stack_top_pointer}, 16'h0040);
    wr(4'h2, 8'h82, 8'h34);
    wr(4'h2, 8'h83, 8'h12);
    wr(4'h2, 8'h99, 8'h41);
    idle();
    #1;
    check(data_pointer_16, 16'h1234);
    check({7'h00, tx_load, tx_byte}, 16'h0141);
    @(posedge ref_clk);
    rx_byte <= 8'h6e;
    rx_load <= 1'b1;
    @(posedge ref_clk);
    rx_load <= 1'b0;
    rd(4'h1, 8'h99, 1'b0, 8'h6e);
    wr(4'h2, 8'h8f, 8'h01);
    wr(4'h2, 8'h80, 8'h0f);
    idle();
    #1;
    check({p0_pullup, p0_oe_n}, 16'hff0f);
    repeat (6) @(posedge ref_clk);
    rd(4'h1, 8'h80, 1'b0, 8'h0f);
    rd(4'h7, 8'h83, 1'b0, 8'h01);
    // far memory answers address xor 55h, unlike the idle pins
    ext(1'b0, 8'h3c, 8'h00);
    check({6'h00, ext_busy, ext_done, ext_rdata}, 16'h0169);
    check({p0_out, p0_oe_n}, 16'h0f0f);
    ext(1'b1, 8'h21, 8'h77);
    check({7'h00, ext_done, wr_seen}, 16'h0177);
    stop_test();
  end
endmodule
`default_nettype wire
